// File: bench/eth_tx_request_buffer_commit_tb.sv
/*
 Self-checking bench of the transmit request and buffer commit block.
 Assumes the strobe timing and register pointers of the design package.
*/
`timescale 1ns/1ps
`default_nettype none

module eth_tx_request_buffer_commit_tb;
    typedef struct packed {logic [15:0] cmd; logic [15:0] len; logic [15:0] slen; logic [1:0] st;} etb_row_s;
    // ==========================================================
    // Stimulus, table and counters
    logic clk = 1'b0, rst_n = 1'b0, pw = 1'b0, dw = 1'b0, dr = 1'b0, fw = 1'b0;
    logic [15:0] wd = 16'h0000;
    logic [4:0] ev = 5'h00;
    logic [15:0] rd, tl, ltl, v, lrd;
    logic [9:0] tbs, ltb = 10'h000, la = 10'h000;
    logic rv, irq, st, ab;
    int failures = 0, total_checks = 0, cyc = 0, nst = 0, nab = 0, c0, wb = 0;
    etb_row_s rows [8] = '{'{16'h00C0, 16'h0002, 16'h0000, 2'b01}, '{16'h00C0, 16'h0003, 16'h0040, 2'b10},
        '{16'h20C0, 16'h0003, 16'h0007, 2'b10}, '{16'h00C0, 16'h05EA, 16'h05EE, 2'b10},
        '{16'h00C0, 16'h05EB, 16'h0000, 2'b01}, '{16'h10C0, 16'h05EE, 16'h05EE, 2'b10},
        '{16'h10C0, 16'h05EF, 16'h0000, 2'b01}, '{16'h3000, 16'h003C, 16'h003C, 2'b10}};
    logic [15:0] evx [5] = '{16'h0100, 16'h8000, 16'h0400, 16'h0200, 16'h0200};

    etb_tx_commit etb_tx_commit_inst (.i_sys_clk(clk), .i_reset_n(rst_n), .i_ptr_wr(pw), .i_data_wr(dw),
        .i_data_rd(dr), .i_frame_wr(fw), .i_wdata(wd), .i_line_done(ev[0]), .i_line_coll16(ev[1]),
        .i_line_jabber(ev[2]), .i_line_late_coll(ev[3]), .i_line_underrun(ev[4]), .i_line_rd_addr(la),
        .o_rdata(rd), .o_rd_valid(rv), .o_irq(irq), .o_tx_start(st), .o_tx_abort(ab), .o_tx_len(tl),
        .o_tx_base(tbs), .o_line_rd_data(lrd));

    initial
    begin
        forever #5 clk = ~clk;
    end

    // Pulses are counted on the falling edge, clear of the edge that launches them.
    always @(negedge clk)
    begin
        cyc++;
        nab += (ab === 1'b1);
        nst += (st === 1'b1);
        ltl = (st === 1'b1) ? tl : ltl;
        ltb = (st === 1'b1) ? tbs : ltb;
        if (cyc == 20000)
        begin
            failures++;
            summarize();
        end
    end
    // ==========================================================
    // Bus and line tasks
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic summarize();
        if (failures == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic acc(input logic [15:0] p, input logic [15:0] d, input logic r, output logic [15:0] q);
        int k;
        @(posedge clk);
        pw <= 1'b1;
        wd <= p;
        @(posedge clk);
        pw <= 1'b0;
        dw <= !r;
        dr <= r;
        wd <= d;
        @(posedge clk);
        dw <= 1'b0;
        dr <= 1'b0;
        k = 0;
        #1;
        while (r && rv !== 1'b1 && k < 4)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        if (r)
            chk("rd_valid", {15'h0000, rv}, 16'h0001);
        q = rd;
    endtask

    task automatic fs(input logic [15:0] n, input logic s);
        int b;
        b = nst;
        for (int i = 0; i < (n + 1) / 2; i++)
        begin
            @(posedge clk);
            fw <= 1'b1;
            wd <= 16'(i);
        end
        @(posedge clk);
        fw <= 1'b0;
        for (int i = 0; i < 20 && nst == b; i++)
            @(posedge clk);
        chk("start", 16'(nst - b), {15'h0000, s});
        if (s)
        begin
            chk("tx_base", {6'h00, ltb}, 16'(wb));
            wb = (wb + (n + 1) / 2) % 1024;
            la <= ltb + 10'h001;
            repeat (2) @(posedge clk);
            #1;
            chk("line_word", lrd, 16'h0001);
        end
    endtask

    task automatic frame(input logic [15:0] c, input logic [15:0] n, input logic [1:0] s);
        acc(etb_pkg::PTR_TX_CMD, c, 1'b0, v);
        acc(etb_pkg::PTR_TX_LEN, n, 1'b0, v);
        acc(etb_pkg::PTR_BUS_STATUS, 16'h0000, 1'b1, v);
        chk("status", v & 16'h0180, {7'h00, s, 7'h00});
        fs(n, s[1]);
    endtask

    task automatic pev(input int j);
        @(posedge clk);
        ev[j] <= 1'b1;
        repeat (4) @(posedge clk);
        ev[j] <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic ok();
        pev(0);
        acc(etb_pkg::PTR_TX_EVENT, 16'h0000, 1'b1, v);
        chk("tx_ok", v, 16'h0100);
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("irq_rst", {15'h0000, irq}, 16'h0000);
        foreach (rows[r])
        begin
            frame(rows[r].cmd, rows[r].len, rows[r].st);
            acc(etb_pkg::PTR_TX_CMD, 16'h0000, 1'b1, v);
            chk("cmd", v, rows[r].cmd);
            if (rows[r].st[1])
            begin
                chk("tx_len", ltl, rows[r].slen);
                ok();
            end
        end
        acc(etb_pkg::PTR_TX_CMD, 16'h00C0, 1'b0, v);
        acc(etb_pkg::PTR_TX_CMD, 16'h0000, 1'b1, v);
        chk("cmd_rd", v, 16'h00C0);
        acc(etb_pkg::PTR_TX_CFG, 16'h8700, 1'b0, v);
        for (int j = 1; j < 5; j++)
        begin
            frame(16'h00C0, 16'h0040, 2'b10);
            c0 = nab;
            pev(j);
            chk("abort", 16'(nab - c0), {15'h0000, j == 4});
            chk("irq", {15'h0000, irq}, {15'h0000, j != 4});
            acc(j == 4 ? etb_pkg::PTR_BUF_EVENT : etb_pkg::PTR_TX_EVENT, 16'h0000, 1'b1, v);
            chk("event", v, evx[j]);
        end
        frame(16'h00C0, 16'h05EA, 2'b10);
        frame(16'h00C0, 16'h03E8, 2'b00);
        c0 = nab;
        acc(etb_pkg::PTR_TX_CMD, 16'h0100, 1'b0, v);
        acc(etb_pkg::PTR_TX_LEN, 16'h0000, 1'b0, v);
        chk("force", 16'(nab - c0), 16'h0001);
        frame(16'h00C0, 16'h03E8, 2'b10);
        ok();
        acc(etb_pkg::PTR_TX_CFG, 16'h0000, 1'b0, v);
        acc(etb_pkg::PTR_BUF_CFG, 16'h0100, 1'b0, v);
        frame(16'h00C0, 16'h05EA, 2'b10);
        frame(16'h00C0, 16'h03E8, 2'b00);
        pev(0);
        chk("irq_ready", {15'h0000, irq}, 16'h0001);
        acc(etb_pkg::PTR_ISQ, 16'h0000, 1'b1, v);
        chk("isq", v, 16'h0100);
        fs(16'h03E8, 1'b1);
        ok();
        summarize();
    end
endmodule // eth_tx_request_buffer_commit_tb

`default_nettype wire

// File: hw/etb_pkg.sv
/*
 Constants, register pointers, bit positions and state type of the
 transmit request and buffer commitment block.
 Assumes a 16-bit port register page reached through a pointer port.
*/
`default_nettype none

package etb_pkg;
    // ==========================================================
    // Register pointers
    localparam logic [15:0] PTR_BUS_STATUS = 16'h0138;
    localparam logic [15:0] PTR_TX_LEN = 16'h0146;
    localparam logic [15:0] PTR_TX_CMD = 16'h0200;
    localparam logic [15:0] PTR_TX_CFG = 16'h0202;
    localparam logic [15:0] PTR_BUF_CFG = 16'h0204;
    localparam logic [15:0] PTR_TX_EVENT = 16'h0206;
    localparam logic [15:0] PTR_BUF_EVENT = 16'h0208;
    localparam logic [15:0] PTR_ISQ = 16'h020A;
    // ==========================================================
    // Field positions
    localparam int BIT_START_LO = 6;
    localparam int BIT_FORCE = 8;
    localparam int BIT_CRC_OFF = 12;
    localparam int BIT_PAD_OFF = 13;
    localparam int BIT_BID_ERR = 7;
    localparam int BIT_READY = 8;
    localparam int BIT_TX_OK = 8;
    localparam int BIT_LATE_COLL = 9;
    localparam int BIT_JABBER = 10;
    localparam int BIT_COLL16 = 15;
    localparam int BIT_UNDERRUN = 9;
    // ==========================================================
    // Lengths, thresholds and reset values
    localparam logic [15:0] LEN_MIN = 16'h0003;
    localparam logic [15:0] LEN_PAD = 16'h003C;
    localparam logic [15:0] LEN_MAX_CRC = 16'h05EA;
    localparam logic [15:0] LEN_MAX_RAW = 16'h05EE;
    localparam logic [15:0] CRC_BYTES = 16'h0004;
    localparam logic [15:0] THR_5 = 16'h0005;
    localparam logic [15:0] THR_381 = 16'h017D;
    localparam logic [15:0] THR_1021 = 16'h03FD;
    localparam logic [15:0] BUF_BYTES = 16'h0800;
    localparam int BUF_WORDS = 1024;
    localparam int ADDR_W = 10;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] TX_EVENT_MASK = 16'h8700;
    localparam logic [15:0] BUF_EVENT_MASK = 16'h0300;
    typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_BID, ST_WAIT, ST_READY, ST_FILL} etb_state_e;
endpackage

`default_nettype wire

// File: hw/etb_tx_commit.sv
/*
 Transmit request, buffer commitment and line event handling of a
 10 Mbit Ethernet port, reached through a pointer port and a data port.
 Assumes line-side event inputs arrive from another clock domain as
 levels held for at least two system clocks.
*/
// What this block does
// R01 - Configuration writes take effect immediately.
// R02 - Enable changes act on current frame.
// R03 - Software changes only allowed line-control bits.
// R04 - Request order: command, length, status read.
// R05 - Command register reads back last write.
// R06 - Command bits 6-9, C, D steer frame; bit 9 is not used by the code.
// R07 - Software writes command before every frame.
// R08 - Software states CRC and pad per request.
// R09 - Polled mode keeps ready interrupt disabled.
// R10 - Invalid length discards bid, sets error.
// R11 - Status reached via pointer 0138h, data port.
// R12 - Polled software waits for ready-now set.
// R13 - Freed space raises ready interrupt.
// R14 - Software moves whole frame through data port.
// R15 - Completion sets transmit-OK flag, interrupt.
// R16 - Compare length with free space.
// R17 - Commit only after ready read.
// R18 - Committed space refuses later frames.
// R19 - Line failures drop frame, own flags.
// R20 - Force clears committed and queued frames.
// R21 - Underrun prevents committed frame transmission.
// R22 - Sent length follows pad and CRC bits.
// R23 - Never send below three bytes.
// R24 - Start after 5, 381, 1021 or all.
// R25 - Discarded bid reserves nothing.
`timescale 1ns/1ps
`default_nettype none

module etb_tx_commit (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_ptr_wr,
    input wire logic i_data_wr,
    input wire logic i_data_rd,
    input wire logic i_frame_wr,
    input wire logic [15:0] i_wdata,
    input wire logic i_line_done,
    input wire logic i_line_coll16,
    input wire logic i_line_jabber,
    input wire logic i_line_late_coll,
    input wire logic i_line_underrun,
    input wire logic [9:0] i_line_rd_addr,
    output logic [15:0] o_rdata,
    output logic o_rd_valid,
    output logic o_irq,
    output logic o_tx_start,
    output logic o_tx_abort,
    output logic [15:0] o_tx_len,
    output logic [9:0] o_tx_base,
    output logic [15:0] o_line_rd_data
);
    // ==========================================================
    // Reset release and line event synchronisers
    logic rst_meta, rst_n;
    logic [4:0] line_s1, line_s2, line_s3;
    logic ev_done, ev_coll16, ev_jabber, ev_late, ev_under;

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Only the second and third stages feed the edge detect.
    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_s1 <= 5'h00;
            line_s2 <= 5'h00;
            line_s3 <= 5'h00;
        end
        else
        begin
            line_s1 <= {i_line_done, i_line_coll16, i_line_jabber, i_line_late_coll, i_line_underrun};
            line_s2 <= line_s1;
            line_s3 <= line_s2;
        end
    end
    assign {ev_done, ev_coll16, ev_jabber, ev_late, ev_under} = line_s2 & ~line_s3;

    // ==========================================================
    // Decode helpers
    // R23 - lengths below three bytes refused
    function automatic logic len_valid(input logic [15:0] len, input logic [15:0] cmd);
        len_valid = (len >= etb_pkg::LEN_MIN) &&
                    (len <= (cmd[etb_pkg::BIT_CRC_OFF] ? etb_pkg::LEN_MAX_RAW : etb_pkg::LEN_MAX_CRC));
    endfunction

    function automatic logic [15:0] sent_len(input logic [15:0] len, input logic [15:0] cmd);
        logic [15:0] padded;
        padded = (!cmd[etb_pkg::BIT_PAD_OFF] && len < etb_pkg::LEN_PAD) ? etb_pkg::LEN_PAD : len;
        sent_len = cmd[etb_pkg::BIT_CRC_OFF] ? padded : padded + etb_pkg::CRC_BYTES;
    endfunction

    function automatic logic [15:0] start_thr(input logic [15:0] len, input logic [15:0] cmd);
        unique case (cmd[etb_pkg::BIT_START_LO +: 2])
            2'b00: start_thr = etb_pkg::THR_5;
            2'b01: start_thr = etb_pkg::THR_381;
            2'b10: start_thr = etb_pkg::THR_1021;
            2'b11: start_thr = len;
        endcase
    endfunction

    // ==========================================================
    // Registers and state
    etb_pkg::etb_state_e state;
    logic [15:0] ptr, transmit_command, transmit_length, transmit_config, buffer_config;
    logic [15:0] transmit_event, buffer_event, fill_count, line_len;
    logic bid_error_flag, line_busy, started;
    logic [9:0] wr_addr, frame_base;
    logic [15:0] buf_mem [etb_pkg::BUF_WORDS];

    // R11 - pointer selects register
    logic wr_cmd, wr_len, rd_status, rd_isq, rd_tx_event, rd_buf_event, force_abort;
    assign wr_cmd = i_data_wr && ptr == etb_pkg::PTR_TX_CMD;
    assign wr_len = i_data_wr && ptr == etb_pkg::PTR_TX_LEN;
    assign rd_status = i_data_rd && ptr == etb_pkg::PTR_BUS_STATUS;
    assign rd_isq = i_data_rd && ptr == etb_pkg::PTR_ISQ;
    assign rd_tx_event = i_data_rd && ptr == etb_pkg::PTR_TX_EVENT;
    assign rd_buf_event = i_data_rd && ptr == etb_pkg::PTR_BUF_EVENT;
    assign force_abort = wr_cmd && i_wdata[etb_pkg::BIT_FORCE];

    // R16 - requested length against free space
    logic space_ok, ready_now_flag, ready_read, start_now;
    logic [15:0] free_bytes, thr_now, sent_now;
    assign free_bytes = etb_pkg::BUF_BYTES - (line_busy ? line_len : 16'h0000);
    assign space_ok = transmit_length <= free_bytes;
    assign ready_now_flag = (state == etb_pkg::ST_BID || state == etb_pkg::ST_WAIT) && space_ok;
    assign ready_read = (rd_buf_event || (rd_isq && |buffer_event)) && buffer_event[etb_pkg::BIT_READY];
    // R06 - command picks start and shape
    assign thr_now = start_thr(transmit_length, transmit_command);
    assign sent_now = sent_len(transmit_length, transmit_command);
    // R24 - start once threshold bytes are buffered
    // A force in the same cycle wins, so the line never starts a dropped frame.
    assign start_now = state == etb_pkg::ST_FILL && !started && !line_busy && !force_abort &&
                       fill_count >= thr_now;

    // ==========================================================
    // Configuration and command registers
    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ptr <= etb_pkg::RST_WORD;
            transmit_command <= etb_pkg::RST_WORD;
            transmit_config <= etb_pkg::RST_WORD;
            buffer_config <= etb_pkg::RST_WORD;
            transmit_length <= etb_pkg::RST_WORD;
        end
        else
        begin
            if (i_ptr_wr)
                ptr <= i_wdata;
            // R05 - command value kept for readback
            if (wr_cmd)
                transmit_command <= i_wdata;
            // R01 - config written with no frame wait
            if (i_data_wr && ptr == etb_pkg::PTR_TX_CFG)
                transmit_config <= i_wdata;
            if (i_data_wr && ptr == etb_pkg::PTR_BUF_CFG)
                buffer_config <= i_wdata;
            if (wr_len && state == etb_pkg::ST_CMD)
                transmit_length <= i_wdata;
        end
    end

    // ==========================================================
    // Request and commitment sequence
    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= etb_pkg::ST_IDLE;
        // R20 - force drops committed frame
        else if (force_abort)
            state <= etb_pkg::ST_IDLE;
        // R04 - a new command restarts the request, except while in ST_FILL
        else if (wr_cmd && state != etb_pkg::ST_FILL)
            state <= etb_pkg::ST_CMD;
        else
        begin
            unique case (state)
                etb_pkg::ST_IDLE: state <= etb_pkg::ST_IDLE;
                etb_pkg::ST_CMD:
                    // R25 - invalid length reserves nothing
                    if (wr_len)
                        state <= len_valid(i_wdata, transmit_command) ? etb_pkg::ST_BID : etb_pkg::ST_IDLE;
                etb_pkg::ST_BID:
                    // R17 - commit only on a ready-now read
                    if (rd_status && space_ok)
                        state <= etb_pkg::ST_FILL;
                    else if (rd_status && buffer_config[etb_pkg::BIT_READY])
                        state <= etb_pkg::ST_WAIT;
                etb_pkg::ST_WAIT:
                    if (rd_status && space_ok)
                        state <= etb_pkg::ST_FILL;
                    else if (space_ok && buffer_config[etb_pkg::BIT_READY])
                        state <= etb_pkg::ST_READY;
                etb_pkg::ST_READY:
                    // R17 - commit only on a ready flag read
                    if (ready_read)
                        state <= etb_pkg::ST_FILL;
                etb_pkg::ST_FILL:
                    if (fill_count >= transmit_length && (started || start_now))
                        state <= etb_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Frame buffer writes and line hand-off
    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fill_count <= etb_pkg::RST_WORD;
            wr_addr <= 10'h000;
            frame_base <= 10'h000;
            started <= 1'b0;
        end
        else
        begin
            if (state != etb_pkg::ST_FILL)
            begin
                fill_count <= etb_pkg::RST_WORD;
                frame_base <= wr_addr;
                started <= 1'b0;
            end
            // R18 - writes only into the committed frame
            else if (i_frame_wr && fill_count < transmit_length)
            begin
                fill_count <= fill_count + 16'h0002;
                wr_addr <= wr_addr + 10'h001;
            end
            if (start_now)
                started <= 1'b1;
        end
    end

    // The memory has no reset; its contents are only meaningful once written.
    always_ff @(posedge i_sys_clk)
    begin
        if (state == etb_pkg::ST_FILL && i_frame_wr && fill_count < transmit_length)
            buf_mem[wr_addr] <= i_wdata;
        o_line_rd_data <= buf_mem[i_line_rd_addr];
    end

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_busy <= 1'b0;
            line_len <= etb_pkg::RST_WORD;
            o_tx_start <= 1'b0;
            o_tx_abort <= 1'b0;
            o_tx_len <= etb_pkg::RST_WORD;
            o_tx_base <= 10'h000;
        end
        else
        begin
            o_tx_start <= start_now;
            // R20 - force also drops the frame on the line
            // R21 - underrun stops the committed frame
            o_tx_abort <= force_abort || (ev_under && line_busy);
            if (start_now)
            begin
                line_busy <= 1'b1;
                line_len <= transmit_length;
                // R22 - pad and CRC shape the sent length
                o_tx_len <= sent_now;
                o_tx_base <= frame_base;
            end
            // R19 - line failures end the frame unsent
            else if (force_abort || ev_done || ev_coll16 || ev_jabber || ev_late || ev_under)
                line_busy <= 1'b0;
        end
    end

    // ==========================================================
    // Event flags, status and interrupt
    logic clr_tx_event, clr_buf_event;
    logic [15:0] tx_set, buf_set, status_word;
    assign clr_buf_event = rd_buf_event || (rd_isq && |buffer_event);
    assign clr_tx_event = rd_tx_event || (rd_isq && !(|buffer_event));
    assign tx_set = ({15'h0000, ev_done && line_busy} << etb_pkg::BIT_TX_OK) |
                    ({15'h0000, ev_coll16 && line_busy} << etb_pkg::BIT_COLL16) |
                    ({15'h0000, ev_jabber && line_busy} << etb_pkg::BIT_JABBER) |
                    ({15'h0000, ev_late && line_busy} << etb_pkg::BIT_LATE_COLL);
    // R13 - freed space raises the ready flag
    assign buf_set = ({15'h0000, state == etb_pkg::ST_WAIT && space_ok && buffer_config[etb_pkg::BIT_READY]
                       && !rd_status} << etb_pkg::BIT_READY) |
                     ({15'h0000, ev_under} << etb_pkg::BIT_UNDERRUN);
    assign status_word = ({15'h0000, ready_now_flag} << etb_pkg::BIT_READY) |
                         ({15'h0000, bid_error_flag} << etb_pkg::BIT_BID_ERR);

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            transmit_event <= etb_pkg::RST_WORD;
            buffer_event <= etb_pkg::RST_WORD;
            bid_error_flag <= 1'b0;
        end
        else
        begin
            // R15 - completion and failures are sticky, set wins
            transmit_event <= (clr_tx_event ? etb_pkg::RST_WORD : transmit_event) | tx_set;
            buffer_event <= (clr_buf_event ? etb_pkg::RST_WORD : buffer_event) | buf_set;
            // R10 - invalid length sets the bid error
            bid_error_flag <= (bid_error_flag && !rd_status) ||
                              (wr_len && state == etb_pkg::ST_CMD && !len_valid(i_wdata, transmit_command));
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_rdata <= etb_pkg::RST_WORD;
            o_rd_valid <= 1'b0;
            o_irq <= 1'b0;
        end
        else
        begin
            o_rd_valid <= i_data_rd;
            if (i_data_rd)
            begin
                unique case (ptr)
                    etb_pkg::PTR_BUS_STATUS: o_rdata <= status_word;
                    etb_pkg::PTR_TX_CMD: o_rdata <= transmit_command;
                    etb_pkg::PTR_TX_LEN: o_rdata <= transmit_length;
                    etb_pkg::PTR_TX_CFG: o_rdata <= transmit_config;
                    etb_pkg::PTR_BUF_CFG: o_rdata <= buffer_config;
                    etb_pkg::PTR_TX_EVENT: o_rdata <= transmit_event;
                    etb_pkg::PTR_BUF_EVENT: o_rdata <= buffer_event;
                    etb_pkg::PTR_ISQ: o_rdata <= (|buffer_event) ? buffer_event : transmit_event;
                    default: o_rdata <= etb_pkg::RST_WORD;
                endcase
            end
            // R02 - enables gate the flags live, mid-frame
            o_irq <= |(transmit_event & transmit_config & etb_pkg::TX_EVENT_MASK) ||
                     |(buffer_event & buffer_config & etb_pkg::BUF_EVENT_MASK);
        end
    end

    // ==========================================================
    // Checks
    sequence s_bad_len;
        state == etb_pkg::ST_CMD && wr_len && !force_abort && !len_valid(i_wdata, transmit_command);
    endsequence
    sequence s_commit;
        state != etb_pkg::ST_FILL ##1 state == etb_pkg::ST_FILL;
    endsequence

    a_bid_error_set: assert property (@(posedge i_sys_clk) disable iff (!rst_n) // R10
        s_bad_len |=> bid_error_flag) else $error("bid error not set");
    a_bid_no_reserve: assert property (@(posedge i_sys_clk) disable iff (!rst_n) // R25
        s_bad_len |=> state == etb_pkg::ST_IDLE && !ready_now_flag) else $error("bad bid kept");
    a_cmd_readback: assert property (@(posedge i_sys_clk) disable iff (!rst_n) // R05
        wr_cmd ##1 (!wr_cmd) [*2] ##1 (i_data_rd && ptr == etb_pkg::PTR_TX_CMD) |=> o_rdata == $past(i_wdata, 4))
        else $error("command readback wrong");
    a_commit_read: assert property (@(posedge i_sys_clk) disable iff (!rst_n) // R17
        s_commit |-> $past(rd_status) || $past(ready_read)) else $error("commit without ready read");
    a_fill_refused: assert property (@(posedge i_sys_clk) disable iff (!rst_n) // R18
        i_frame_wr && state != etb_pkg::ST_FILL |=> $stable(wr_addr)) else $error("write outside commit");
    a_force_clear: assert property (@(posedge i_sys_clk) disable iff (!rst_n) // R20
        force_abort |=> state == etb_pkg::ST_IDLE && !line_busy && o_tx_abort) else $error("force ignored");
    a_tx_ok_irq: assert property (@(posedge i_sys_clk) disable iff (!rst_n) // R15
        ev_done && line_busy && transmit_config[etb_pkg::BIT_TX_OK] && !clr_tx_event |=> ##1 o_irq)
        else $error("transmit ok lost");
    a_fail_flag: assert property (@(posedge i_sys_clk) disable iff (!rst_n) // R19
        ev_coll16 && line_busy |=> transmit_event[etb_pkg::BIT_COLL16] && !line_busy) else $error("failure lost");
    a_underrun_stop: assert property (@(posedge i_sys_clk) disable iff (!rst_n) // R21
        ev_under && line_busy && !start_now |=> o_tx_abort && !line_busy) else $error("underrun ignored");
    a_sent_length: assert property (@(posedge i_sys_clk) disable iff (!rst_n) // R22
        start_now |=> o_tx_start && o_tx_len == $past(sent_now)) else $error("sent length wrong");
    a_min_length: assert property (@(posedge i_sys_clk) disable iff (!rst_n) // R23
        o_tx_start |-> line_len >= etb_pkg::LEN_MIN) else $error("short frame sent");
    a_start_thresh: assert property (@(posedge i_sys_clk) disable iff (!rst_n) // R24
        o_tx_start |-> $past(fill_count) >= $past(thr_now)) else $error("early start");
    a_ready_irq: assert property (@(posedge i_sys_clk) disable iff (!rst_n) // R13
        state == etb_pkg::ST_WAIT && space_ok && buffer_config[etb_pkg::BIT_READY] && !rd_status && !wr_cmd
        |=> buffer_event[etb_pkg::BIT_READY] ##1 o_irq) else $error("ready interrupt missing");
endmodule // etb_tx_commit

`default_nettype wire
